/* File: hw/asr_pkg.sv */
// shared constants and types of the serial register access block
// assumes a single system clock; serial pins already synchronous to it
`default_nettype none

package asr_pkg;

    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned PAYLOAD_W   = 12;
    localparam int unsigned SEL_W       = 3;
    localparam int unsigned CNT_W       = 5;

    // register select codes
    localparam logic [SEL_W-1:0] SEL_NOP0  = 3'h0;
    localparam logic [SEL_W-1:0] SEL_CFG1  = 3'h1;
    localparam logic [SEL_W-1:0] SEL_CFG2  = 3'h2;
    localparam logic [SEL_W-1:0] SEL_ALERT = 3'h3;
    localparam logic [SEL_W-1:0] SEL_LOLIM = 3'h4;
    localparam logic [SEL_W-1:0] SEL_HILIM = 3'h5;
    localparam logic [SEL_W-1:0] SEL_NOP6  = 3'h6;
    localparam logic [SEL_W-1:0] SEL_NOP7  = 3'h7;

    // reset values of the payload fields
    localparam logic [PAYLOAD_W-1:0] CFG1_RST  = 12'h000;
    localparam logic [PAYLOAD_W-1:0] CFG2_RST  = 12'h000;
    localparam logic [PAYLOAD_W-1:0] LOLIM_RST = 12'h000;
    localparam logic [PAYLOAD_W-1:0] HILIM_RST = 12'hfff;
    localparam logic [PAYLOAD_W-1:0] ALERT_RST = 12'h000;

    // checksum write protection bit inside primary configuration
    localparam int unsigned CFG1_CRC_W_BIT = 5;

    localparam logic [FRAME_BITS-1:0] WORD_ZERO = 16'h0000;

    typedef struct packed {
        logic                 wr;
        logic [SEL_W-1:0]     register_select;
        logic [PAYLOAD_W-1:0] payload;
    } asr_frame_t;

endpackage : asr_pkg

`default_nettype wire

/* File: hw/asr_regbank.sv */
// register bank behind the serial frame: decode, write, read-back select
// assumes an outside checksum checker reports each frame's checksum validity
`default_nettype none

// What this block does
// - A frame counts only if exactly sixteen serial clocks arrived inside chip select.
// - Bit 15 is the write flag, bits 14 to 12 the register select, bits 11 to 0 the payload.
// - A write flag of one to a writable register loads the twelve payload bits into it.
// - A read to a valid register sends that register out during the next frame.
// - A read with select 0, 6 or 7 does nothing and the next frame carries conversion data.
// - A write to the read-only alert status register changes nothing.
// - No register is write-only, so a read to any valid register is answered.
// - A write to an undefined select is discarded without any effect.
// - With checksum protection on, a write without a valid checksum is ignored.
module asr_regbank (
    input  wire logic                           clk_sys,
    input  wire logic                           rstn,
    input  wire logic                           sclk,
    input  wire logic                           cs_n,
    input  wire logic                           sdi,
    input  wire logic                           crc_valid,
    input  wire logic [asr_pkg::FRAME_BITS-1:0] conv_data,
    input  wire logic [asr_pkg::PAYLOAD_W-1:0]  alert_flags,
    output logic                                primary_serial_output,
    output logic [asr_pkg::PAYLOAD_W-1:0]       primary_configuration_q,
    output logic [asr_pkg::PAYLOAD_W-1:0]       secondary_configuration_q,
    output logic [asr_pkg::PAYLOAD_W-1:0]       lower_limit_threshold_q,
    output logic [asr_pkg::PAYLOAD_W-1:0]       upper_limit_threshold_q
);
    import asr_pkg::*;

    asr_frame_t            frame;
    logic                  frame_done;
    logic [FRAME_BITS-1:0] tx_word;
    logic [PAYLOAD_W-1:0]  alert_status_q;
    logic                  pend_valid_q;
    logic [SEL_W-1:0]      pend_sel_q;
    logic                  wr_writable;
    logic                  rd_readable;
    logic                  wr_blocked;
    logic                  do_write;
    logic [PAYLOAD_W-1:0]  rd_data;

    // =====================================================
    // serial shifter
    asr_shifter i_asr_shifter (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .sclk         (sclk),
        .cs_n         (cs_n),
        .sdi          (sdi),
        .tx_word      (tx_word),
        .frame_q      (frame),
        .frame_done_q (frame_done),
        .sdo_q        (primary_serial_output)
    );

    // =====================================================
    // decode
    // select from top bits
    always_comb begin
        unique case (frame.register_select)
            SEL_CFG1, SEL_CFG2, SEL_LOLIM, SEL_HILIM: wr_writable = 1'b1;
            default:                                  wr_writable = 1'b0;
        endcase
    end

    always_comb begin
        unique case (frame.register_select)
            SEL_CFG1, SEL_CFG2, SEL_ALERT, SEL_LOLIM, SEL_HILIM: rd_readable = 1'b1;
            default:                                             rd_readable = 1'b0;
        endcase
    end

    assign wr_blocked = primary_configuration_q[CFG1_CRC_W_BIT] && !crc_valid;

    // read-only and undefined selects fall out
    assign do_write = frame_done && frame.wr && wr_writable && !wr_blocked;

    // =====================================================
    // writable registers
    // payload load
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            primary_configuration_q   <= CFG1_RST;
            secondary_configuration_q <= CFG2_RST;
            lower_limit_threshold_q   <= LOLIM_RST;
            upper_limit_threshold_q   <= HILIM_RST;
        end else if (do_write) begin
            unique case (frame.register_select)
                SEL_CFG1:  primary_configuration_q   <= frame.payload;
                SEL_CFG2:  secondary_configuration_q <= frame.payload;
                SEL_LOLIM: lower_limit_threshold_q   <= frame.payload;
                SEL_HILIM: upper_limit_threshold_q   <= frame.payload;
                default:   ;
            endcase
        end
    end

    // =====================================================
    // alert status mirrors the comparator flags
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            alert_status_q <= ALERT_RST;
        end else begin
            alert_status_q <= alert_flags;
        end
    end

    // =====================================================
    // pending read for the next frame
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pend_valid_q <= 1'b0;
            pend_sel_q   <= SEL_NOP0;
        end else if (frame_done) begin
            // no write-only register exists to refuse
            pend_valid_q <= !frame.wr && rd_readable;
            pend_sel_q   <= frame.register_select;
        end
    end

    always_comb begin
        unique case (pend_sel_q)
            SEL_CFG1:  rd_data = primary_configuration_q;
            SEL_CFG2:  rd_data = secondary_configuration_q;
            SEL_ALERT: rd_data = alert_status_q;
            SEL_LOLIM: rd_data = lower_limit_threshold_q;
            default:   rd_data = upper_limit_threshold_q;
        endcase
    end

    // answer word carries its address field
    assign tx_word = pend_valid_q ? {1'b0, pend_sel_q, rd_data} : conv_data;

    // =====================================================
    // checks
    AST_WRITE_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_LOLIM && !wr_blocked)
        |=> lower_limit_threshold_q == $past(frame.payload))
        else $error("write did not load threshold");

    AST_RO_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_ALERT)
        |=> $stable(primary_configuration_q) && $stable(secondary_configuration_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("write to read-only register changed state");

    AST_NOP_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && (frame.register_select == SEL_NOP0
            || frame.register_select == SEL_NOP6 || frame.register_select == SEL_NOP7))
        |=> $stable(primary_configuration_q) && $stable(upper_limit_threshold_q))
        else $error("undefined write changed state");

    AST_READ_PEND: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && !frame.wr && frame.register_select >= SEL_CFG1
            && frame.register_select <= SEL_HILIM)
        |=> pend_valid_q && pend_sel_q == $past(frame.register_select))
        else $error("read request not queued");

    AST_NOP_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && !frame.wr && !rd_readable) |=> (!pend_valid_q && tx_word == conv_data))
        else $error("nop read did not return conversion data");

    AST_CRC_GUARD: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && primary_configuration_q[CFG1_CRC_W_BIT] && !crc_valid)
        |=> $stable(primary_configuration_q) && $stable(secondary_configuration_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("protected write without checksum accepted");

    AST_CRC_OPEN: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_CFG1 && crc_valid)
        |=> primary_configuration_q == $past(frame.payload))
        else $error("write with valid checksum refused");

    AST_WRITE_CFG1: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_CFG1 && !wr_blocked)
        |=> primary_configuration_q == $past(frame.payload))
        else $error("write did not load primary configuration");

    AST_WRITE_CFG2: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_CFG2 && !wr_blocked)
        |=> secondary_configuration_q == $past(frame.payload))
        else $error("write did not load secondary configuration");

    AST_WRITE_HILIM: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr && frame.register_select == SEL_HILIM && !wr_blocked)
        |=> upper_limit_threshold_q == $past(frame.payload))
        else $error("write did not load upper threshold");

    AST_QUIET_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        !frame_done
        |=> $stable(primary_configuration_q) && $stable(secondary_configuration_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("register changed outside a complete frame");

    AST_RD_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && !frame.wr)
        |=> $stable(primary_configuration_q) && $stable(secondary_configuration_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("read request changed register state");

    AST_PEND_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        !frame_done |=> $stable(pend_valid_q) && $stable(pend_sel_q))
        else $error("pending read changed outside a complete frame");

    AST_WRITE_NO_PEND: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frame_done && frame.wr) |=> !pend_valid_q)
        else $error("write frame queued a read answer");

    // =====================================================
    // elaboration checks on the frame layout
    if (FRAME_BITS != 1 + SEL_W + PAYLOAD_W) begin : g_bad_layout
        $error("frame fields do not fill the frame");
    end
    if ((1 << CNT_W) <= FRAME_BITS + 1) begin : g_bad_count
        $error("bit counter too narrow for the frame");
    end

endmodule : asr_regbank

`default_nettype wire

/* File: hw/asr_shifter.sv */
// serial frame shifter: counts serial clock edges inside chip select
// assumes sclk, cs_n and sdi are synchronous to clk_sys and slower than it
`default_nettype none

module asr_shifter (
    input  wire logic                           clk_sys,
    input  wire logic                           rstn,
    input  wire logic                           sclk,
    input  wire logic                           cs_n,
    input  wire logic                           sdi,
    input  wire logic [asr_pkg::FRAME_BITS-1:0] tx_word,
    output var  asr_pkg::asr_frame_t            frame_q,
    output logic                                frame_done_q,
    output logic                                sdo_q
);
    import asr_pkg::*;

    logic                  sclk_q;
    logic                  cs_n_q;
    logic [CNT_W-1:0]      cnt_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic                  rise;
    logic                  fall;
    logic                  start;
    logic                  stop;

    assign rise  = sclk & ~sclk_q & ~cs_n;
    assign fall  = ~sclk & sclk_q & ~cs_n;
    assign start = ~cs_n & cs_n_q;
    assign stop  = cs_n & ~cs_n_q;

    // =====================================================
    // edge history
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
            cs_n_q <= cs_n;
        end
    end

    // =====================================================
    // receive side, saturating bit count
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= '0;
            rx_q  <= WORD_ZERO;
        end else if (start) begin
            cnt_q <= '0;
        end else if (rise) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], sdi};
            if (cnt_q != '1) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            frame_done_q <= 1'b0;
            frame_q      <= '0;
        end else begin
            frame_done_q <= stop && (cnt_q == CNT_W'(FRAME_BITS));
            if (stop) begin
                frame_q <= asr_frame_t'(rx_q);
            end
        end
    end

    // =====================================================
    // transmit side, msb first, changes on falling edge
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_q  <= WORD_ZERO;
            sdo_q <= 1'b0;
        end else if (start) begin
            tx_q  <= tx_word;
            sdo_q <= tx_word[FRAME_BITS-1];
        end else if (fall) begin
            tx_q  <= {tx_q[FRAME_BITS-2:0], 1'b0};
            sdo_q <= tx_q[FRAME_BITS-2];
        end
    end

    AST_FRAME_LEN: assert property (@(posedge clk_sys) disable iff (!rstn)
        frame_done_q |-> $past(cnt_q) == CNT_W'(FRAME_BITS))
        else $error("frame accepted with wrong bit count");

    AST_SHORT_DROP: assert property (@(posedge clk_sys) disable iff (!rstn)
        (stop && cnt_q != CNT_W'(FRAME_BITS)) |=> !frame_done_q)
        else $error("frame of wrong length accepted");

    AST_SDO_MSB: assert property (@(posedge clk_sys) disable iff (!rstn)
        start |=> (sdo_q == $past(tx_word[FRAME_BITS-1])) && (tx_q == $past(tx_word)))
        else $error("first output bit is not answer msb");

endmodule : asr_shifter

`default_nettype wire

/* File: test/adc_serial_register_access_tb_top.sv */
// self-checking bench for the serial register bank
// assumes asr_pkg and asr_regbank compiled first; host model drives the pins
`default_nettype none

module adc_serial_register_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import asr_pkg::*;

    logic        clk_sys, rstn, sclk, cs_n, sdi, crc_valid, output_lane_select;
    logic [15:0] conv_data;
    logic [11:0] alert_flags, cfg1, cfg2, lolim, hilim;
    logic [15:0] rx;
    int          err_count = 0;
    int          tests_run = 0;

    asr_regbank i_asr_regbank (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .crc_valid(crc_valid), .conv_data(conv_data), .alert_flags(alert_flags),
        .primary_serial_output(output_lane_select), .primary_configuration_q(cfg1),
        .secondary_configuration_q(cfg2), .lower_limit_threshold_q(lolim),
        .upper_limit_threshold_q(hilim));

    asr_host_model i_asr_host_model (.clk_sys(clk_sys), .output_lane_select(output_lane_select), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi));

    // ==========================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_regs(input logic [47:0] exp);
        chk({4'h0, cfg1}, {4'h0, exp[47:36]});
        chk({4'h0, cfg2}, {4'h0, exp[35:24]});
        chk({4'h0, lolim}, {4'h0, exp[23:12]});
        chk({4'h0, hilim}, {4'h0, exp[11:0]});
    endtask : chk_regs

    task automatic frame(input logic wr, input logic [2:0] sel, input logic [11:0] val);
        i_asr_host_model.xfer({wr, sel, val}, 0, rx);
    endtask : frame

    // ==========================================
    // scenarios
    task automatic sc_write;
        chk_regs({CFG1_RST, CFG2_RST, LOLIM_RST, HILIM_RST});
        frame(1'b1, SEL_CFG1, 12'h7df);
        frame(1'b1, SEL_CFG2, 12'h0a5);
        frame(1'b1, SEL_LOLIM, 12'h123);
        frame(1'b1, SEL_HILIM, 12'h9ab);
        chk_regs({12'h7df, 12'h0a5, 12'h123, 12'h9ab});
    endtask : sc_write

    task automatic sc_refused;
        logic [2:0] bad [4] = '{SEL_NOP0, SEL_ALERT, SEL_NOP6, SEL_NOP7};
        foreach (bad[i]) frame(1'b1, bad[i], 12'hfff);
        chk_regs({12'h7df, 12'h0a5, 12'h123, 12'h9ab});
        i_asr_host_model.xfer({1'b1, SEL_LOLIM, 12'hfff}, -1, rx);
        i_asr_host_model.xfer({1'b1, SEL_LOLIM, 12'hfff}, 1, rx);
        chk({4'h0, lolim}, 16'h0123);
    endtask : sc_refused

    task automatic sc_read;
        logic [2:0]  nop [3] = '{SEL_NOP0, SEL_NOP6, SEL_NOP7};
        logic [2:0]  rsel [3] = '{SEL_CFG1, SEL_CFG2, SEL_HILIM};
        logic [11:0] rval [3] = '{12'h7df, 12'h0a5, 12'h9ab};
        foreach (rsel[i]) begin
            frame(1'b0, rsel[i], 12'h000);
            frame(1'b0, SEL_NOP0, 12'h000);
            chk(rx, {1'b0, rsel[i], rval[i]});
        end
        frame(1'b0, SEL_LOLIM, 12'h000);
        frame(1'b0, SEL_NOP0, 12'h000);
        chk(rx, {1'b0, SEL_LOLIM, 12'h123});
        alert_flags <= 12'ha5c;
        frame(1'b0, SEL_ALERT, 12'h000);
        frame(1'b0, SEL_NOP0, 12'h000);
        chk(rx, {1'b0, SEL_ALERT, 12'ha5c});
        foreach (nop[i]) begin
            conv_data <= 16'hc3e1 + 16'(i);
            frame(1'b0, nop[i], 12'hfff);
            frame(1'b0, SEL_NOP0, 12'h000);
            chk(rx, 16'hc3e1 + 16'(i));
        end
    endtask : sc_read

    task automatic sc_crc;
        frame(1'b1, SEL_CFG1, 12'h020);
        frame(1'b1, SEL_LOLIM, 12'h555);
        frame(1'b1, SEL_CFG1, 12'h000);
        chk({cfg1, lolim[3:0]}, 16'h0203);
        crc_valid <= 1'b1;
        frame(1'b1, SEL_CFG1, 12'h000);
        frame(1'b1, SEL_LOLIM, 12'h555);
        chk({cfg1, lolim[3:0]}, 16'h0005);
    endtask : sc_crc

    // mid-run reset drops stored values and the pending read
    task automatic sc_reset;
        frame(1'b1, SEL_HILIM, 12'h3c4);
        frame(1'b0, SEL_CFG2, 12'h000);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk_regs({CFG1_RST, CFG2_RST, LOLIM_RST, HILIM_RST});
        conv_data <= 16'h5a69;
        frame(1'b0, SEL_NOP0, 12'h000);
        chk(rx, 16'h5a69);
    endtask : sc_reset

    task automatic final_report;
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ==========================================
    // clock, reset and sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        rstn        = 1'b0;
        crc_valid   = 1'b0;
        conv_data   = 16'h0000;
        alert_flags = 12'h000;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sc_write();
        sc_refused();
        sc_read();
        sc_crc();
        sc_reset();
        final_report();
    end
endmodule : adc_serial_register_access_tb_top

`default_nettype wire

/* File: test/asr_host_model.sv */
// host serial controller model driving frames into the register access block
// assumes clk_sys is the system clock; all pins change just after its rise
`default_nettype none

module asr_host_model (
    input  wire logic clk_sys,
    input  wire logic output_lane_select,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // ==========================================
    // frame transfer
    // sixteen clocks, msb first
    // adj -1 drops the last bit, +1 appends one
    task automatic xfer(input logic [15:0] tx, input int adj, output logic [15:0] rx);
        rx = 16'h0000;
        tick(1);
        cs_n <= 1'b0;
        for (int i = 0; i < 16 + adj; i++) begin
            sdi <= (i < 16) ? tx[15-i] : 1'b0;
            tick(3);
            rx = {rx[14:0], output_lane_select};
            sclk <= 1'b1;
            tick(3);
            sclk <= 1'b0;
        end
        tick(3);
        cs_n <= 1'b1;
        // released line: no stale value
        sdi  <= ~sdi;
        tick(6);
    endtask : xfer
endmodule : asr_host_model

`default_nettype wire
